// ===== design/sdc_pkg.sv
// Shared constants and types for the synthesizer configuration loader.
package sdc_pkg;

  // Divider field widths.
  localparam int unsigned FB_W    = 9;
  localparam int unsigned OD_W    = 2;
  localparam int unsigned DIAG_W  = 2;
  localparam int unsigned FRAME_W = DIAG_W + OD_W + FB_W;

  // Serial frame layout, least significant bit first in the word.
  localparam int unsigned FRAME_FB_LSB   = 0;
  localparam int unsigned FRAME_OD_LSB   = FB_W;
  localparam int unsigned FRAME_DIAG_LSB = FB_W + OD_W;

  // Output divide ratios selected by the 2-bit code.
  localparam logic [8:0] OD_RATIO_0 = 9'h003;
  localparam logic [8:0] OD_RATIO_1 = 9'h004;
  localparam logic [8:0] OD_RATIO_2 = 9'h005;
  localparam logic [8:0] OD_RATIO_3 = 9'h006;

  // Smallest ratio the divider can honour with a 50 percent duty cycle.
  localparam logic [8:0] MIN_RATIO = 9'h002;

  // Diagnostic output source codes.
  localparam logic [1:0] DIAG_LOW   = 2'h0;
  localparam logic [1:0] DIAG_SDATA = 2'h1;
  localparam logic [1:0] DIAG_FB    = 2'h2;
  localparam logic [1:0] DIAG_FOUT  = 2'h3;

  // APB register byte addresses.
  localparam int unsigned ADDR_W    = 12;
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;

  // Control register fields and reset value.
  localparam int unsigned CTRL_SOFT_RST = 0;
  localparam int unsigned CTRL_BYP_INV  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;

  // Status register field positions.
  localparam int unsigned STAT_FB_LSB   = 0;
  localparam int unsigned STAT_OD_LSB   = 9;
  localparam int unsigned STAT_DIAG_LSB = 11;
  localparam int unsigned STAT_PAR_BIT  = 13;
  localparam int unsigned STAT_RST_BIT  = 14;

  // Loaded divider configuration.
  typedef struct packed {
    logic [DIAG_W-1:0] diag;
    logic [OD_W-1:0]   od;
    logic [FB_W-1:0]   fb;
  } sdc_cfg_t;

  localparam sdc_cfg_t CFG_RESET = '0;

  // APB request and answer bundles.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sdc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sdc_apb_rsp_t;

endpackage

// ===== design/sdc_divider.sv
// Tick-driven integer divider with near 50 percent duty output.
`timescale 1ns/10ps
module sdc_divider (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [8:0] ratio,
  output logic            div_out
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic [8:0] lim;
  logic [8:0] high_len;
  logic       out_q;

  // Ratios below two cannot toggle at half rate, so they are raised to two.
  always_comb begin
    lim      = (ratio < sdc_pkg::MIN_RATIO) ? sdc_pkg::MIN_RATIO : ratio;
    high_len = lim - (lim >> 1);
    cnt_d    = (cnt_q >= lim - 9'h001) ? 9'h000 : cnt_q + 9'h001;
  end

  // Counter and output advance only on a source tick; clear holds both low.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 9'h000;
      out_q <= 1'b0;
    end else if (clear) begin
      cnt_q <= 9'h000;
      out_q <= 1'b0;
    end else if (tick) begin
      cnt_q <= cnt_d;
      out_q <= (cnt_d < high_len);
    end
  end

  // The output is the registered phase, free of decode glitches.
  assign div_out = out_q;

endmodule

// ===== design/sdc_config_loader.sv
// Configuration loader and output control for the clock synthesizer.
//
// Summary of operation
// - Divider reset high clears dividers and drives both clock outputs low.
// - Divider reset leaves loaded feedback, output and diagnostic values intact.
// - Serial mode shifts one data bit per serial clock rising edge.
// - Transfer strobe rising with serial clock low loads shift register.
// - Transfer strobe falling freezes divider values against further shifting.
// - Transfer strobe held high updates dividers on each serial clock rise.
// - Parallel strobe low passes pin values through and forces diagnostic low.
// - Parallel strobe rising latches pin values until next fall or serial load.
// - Feedback field is nine bits, output divide field is two bits.
// - Feedback divide is the plain unsigned binary value of its bits.
// - Output code 00,01,10,11 selects divide by 3,4,5,6.
// - Each clock output is enabled or floated by its own enable.
// - Reference select high uses crystal, low uses alternate reference.
// - Bypass select chooses PLL or bypass; polarity is software adjustable.
// - Diagnostic bits pick low, serial data, feedback output or synthesized clock.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module sdc_config_loader (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // Configuration pins.
  input  wire logic                 divider_reset,
  input  wire logic                 parallel_latch_strobe_low,
  input  wire logic [8:0]           fb_div_pins,
  input  wire logic [1:0]           od_div_pins,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_data,
  input  wire logic                 serial_load,
  input  wire logic                 reference_source_select,
  input  wire logic                 pll_bypass_select,
  input  wire logic                 first_output_enable,
  input  wire logic                 second_output_enable,
  input  wire logic                 xtal_in,
  input  wire logic                 alt_ref_clk,
  // Clock and diagnostic outputs.
  output logic                      first_clock_out,
  output logic                      first_clock_out_en,
  output logic                      second_clock_out,
  output logic                      second_clock_out_en,
  output logic                      diag_out,
  // APB slave.
  input  wire sdc_pkg::sdc_apb_req_t apb_req,
  output sdc_pkg::sdc_apb_rsp_t      apb_rsp
);

  // Map an output divide code onto its ratio.
  function automatic logic [8:0] od_ratio(input logic [1:0] code);
    logic [8:0] r;
    r = sdc_pkg::OD_RATIO_0;
    unique case (code)
      2'h0: r = sdc_pkg::OD_RATIO_0;
      2'h1: r = sdc_pkg::OD_RATIO_1;
      2'h2: r = sdc_pkg::OD_RATIO_2;
      2'h3: r = sdc_pkg::OD_RATIO_3;
    endcase
    return r;
  endfunction

  // Reassemble a configuration from a serial frame word.
  function automatic sdc_pkg::sdc_cfg_t frame_cfg(input logic [12:0] w);
    sdc_pkg::sdc_cfg_t c;
    c.fb   = w[sdc_pkg::FRAME_FB_LSB +: sdc_pkg::FB_W];
    c.od   = w[sdc_pkg::FRAME_OD_LSB +: sdc_pkg::OD_W];
    c.diag = w[sdc_pkg::FRAME_DIAG_LSB +: sdc_pkg::DIAG_W];
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Input edge detection

  logic sclk_q;
  logic sload_q;
  logic pstrobe_q;
  logic ref_q;
  logic ref_sel;

  // Previous values of the strobes, used only to find their edges.
  // Reset values match the pulled-down idle pins, so a strobe already high
  // when reset lifts counts as a rise and latches the strapped pins.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q    <= 1'b0;
      sload_q   <= 1'b0;
      pstrobe_q <= 1'b0;
      ref_q     <= 1'b0;
    end else begin
      sclk_q    <= serial_clk;
      sload_q   <= serial_load;
      pstrobe_q <= parallel_latch_strobe_low;
      ref_q     <= ref_sel;
    end
  end

  // Decoded edges and modes.
  logic sclk_rise;
  logic sload_rise;
  logic sload_fall;
  logic pstrobe_rise;
  logic par_mode;
  logic ser_mode;

  // Source choice for the reference input.
  assign ref_sel      = reference_source_select ? xtal_in : alt_ref_clk;
  assign sclk_rise    = serial_clk & ~sclk_q;
  assign sload_rise   = serial_load & ~sload_q;
  assign sload_fall   = ~serial_load & sload_q;
  assign pstrobe_rise = parallel_latch_strobe_low & ~pstrobe_q;
  assign par_mode     = ~parallel_latch_strobe_low;
  assign ser_mode     = parallel_latch_strobe_low & ~pstrobe_rise;

  //////////////////////////////////////////////////////////////////////////////
  // Serial shift register

  // Thirteen bit frame; extra bits push the oldest out of the top.
  logic [12:0] shift_q;
  logic [12:0] shift_d;

  // New bit enters at the bottom so the first bit sent ends at the top.
  assign shift_d = {shift_q[11:0], serial_data};

  // Shifting is gated off while the divider reset pin is high; software reset does not gate it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= 13'h0000;
    end else if (!divider_reset && ser_mode && sclk_rise) begin
      shift_q <= shift_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loaded configuration

  sdc_pkg::sdc_cfg_t cfg_q;

  // Parallel pins pass through while the strobe is low and are frozen by its
  // rise; serial loads then override until the strobe falls again.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= sdc_pkg::CFG_RESET;
    end else if (divider_reset) begin
      cfg_q <= cfg_q;
    end else if (par_mode || (pstrobe_rise && !serial_load)) begin
      cfg_q.fb   <= fb_div_pins;
      cfg_q.od   <= od_div_pins;
      cfg_q.diag <= sdc_pkg::DIAG_LOW;
    end else if (ser_mode && serial_load && sclk_rise) begin
      cfg_q <= frame_cfg(shift_d);
    end else if (ser_mode && sload_rise && !serial_clk) begin
      cfg_q <= frame_cfg(shift_q);
    end else if (ser_mode && sload_fall) begin
      cfg_q <= cfg_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register and divider chain

  // Software control bits and divider chain nets.
  logic [1:0] ctrl_q;
  logic       div_clear;
  logic       bypass;
  logic       ref_tick;
  logic       src_tick;
  logic       fb_out;
  logic       fout;

  // Software reset adds to the pin; configuration is never touched by either.
  assign div_clear = divider_reset | ctrl_q[sdc_pkg::CTRL_SOFT_RST];
  assign bypass    = pll_bypass_select ^ ctrl_q[sdc_pkg::CTRL_BYP_INV];
  assign ref_tick  = ref_sel & ~ref_q;
  // The core clock stands in for the oscillator when locked; bypass uses the
  // reference edges directly, so output rates are only representative.
  assign src_tick  = bypass ? ref_tick : 1'b1;

  // Feedback divider, ratio taken as a plain unsigned number.
  sdc_divider u_fb_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clear    (div_clear),
    .tick     (src_tick),
    .ratio    (cfg_q.fb),
    .div_out  (fb_out)
  );

  // Output divider shared by both clock outputs.
  sdc_divider u_out_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clear    (div_clear),
    .tick     (src_tick),
    .ratio    (od_ratio(cfg_q.od)),
    .div_out  (fout)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Output registers

  logic q0_q;
  logic q1_q;
  logic q0_en_q;
  logic q1_en_q;
  logic diag_q;

  // Clock outputs go low during divider reset; enables act independently.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q0_q    <= 1'b0;
      q1_q    <= 1'b0;
      q0_en_q <= 1'b0;
      q1_en_q <= 1'b0;
    end else begin
      q0_q    <= div_clear ? 1'b0 : fout;
      q1_q    <= div_clear ? 1'b0 : fout;
      q0_en_q <= first_output_enable;
      q1_en_q <= second_output_enable;
    end
  end

  // Diagnostic source; parallel mode always forces it low.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      diag_q <= 1'b0;
    end else if (par_mode) begin
      diag_q <= 1'b0;
    end else begin
      unique case (cfg_q.diag)
        sdc_pkg::DIAG_LOW:   diag_q <= 1'b0;
        sdc_pkg::DIAG_SDATA: diag_q <= serial_data;
        sdc_pkg::DIAG_FB:    diag_q <= fb_out;
        sdc_pkg::DIAG_FOUT:  diag_q <= fout;
      endcase
    end
  end

  // Every pin output is a plain copy of its flip-flop.
  assign first_clock_out     = q0_q;
  assign second_clock_out    = q1_q;
  assign first_clock_out_en  = q0_en_q;
  assign second_clock_out_en = q1_en_q;
  assign diag_out            = diag_q;

  //////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Bus decode, answer registers and the read view.
  logic        setup;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [31:0] stat_word;
  logic        rdy_q;
  logic        err_q;
  logic [31:0] rdata_q;

  // Decode is combinational so the answer can be registered at the setup edge.
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign hit_ctrl = (apb_req.paddr == sdc_pkg::CTRL_ADDR);
  assign hit_stat = (apb_req.paddr == sdc_pkg::STAT_ADDR);

  // Live view of the loaded configuration and mode.
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[sdc_pkg::STAT_FB_LSB +: sdc_pkg::FB_W]     = cfg_q.fb;
    stat_word[sdc_pkg::STAT_OD_LSB +: sdc_pkg::OD_W]     = cfg_q.od;
    stat_word[sdc_pkg::STAT_DIAG_LSB +: sdc_pkg::DIAG_W] = cfg_q.diag;
    stat_word[sdc_pkg::STAT_PAR_BIT]                     = par_mode;
    stat_word[sdc_pkg::STAT_RST_BIT]                     = div_clear;
  end

  // Answer is registered, so every transfer takes exactly one access cycle.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rdy_q <= setup;
      err_q <= setup & ~(hit_ctrl | hit_stat);
      if (setup && !apb_req.pwrite) begin
        rdata_q <= hit_ctrl ? {30'h0000_0000, ctrl_q} : (hit_stat ? stat_word : 32'h0000_0000);
      end
    end
  end

  // Control write lands at the completing access edge.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= sdc_pkg::CTRL_RESET;
    end else if (apb_req.psel && apb_req.penable && rdy_q && apb_req.pwrite && hit_ctrl) begin
      ctrl_q <= apb_req.pwdata[1:0];
    end
  end

  // Answer fields come straight from their flip-flops.
  assign apb_rsp.pready  = rdy_q;
  assign apb_rsp.pslverr = err_q;
  assign apb_rsp.prdata  = rdata_q;

endmodule

// ===== testbench/sdc_config_loader_assertions.sv
// Port-level checker for the synthesizer configuration loader.
`timescale 1ns/10ps
module sdc_chk (
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  input wire logic                  divider_reset,
  input wire logic                  parallel_latch_strobe_low,
  input wire logic                  first_output_enable,
  input wire logic                  second_output_enable,
  input wire logic                  first_clock_out,
  input wire logic                  first_clock_out_en,
  input wire logic                  second_clock_out,
  input wire logic                  second_clock_out_en,
  input wire logic                  diag_out,
  input wire sdc_pkg::sdc_apb_req_t apb_req,
  input wire sdc_pkg::sdc_apb_rsp_t apb_rsp
);
  ////////////////////////////////////////////////////////////////////////////////
  // The first edge after release has no valid past sample, so it is skipped.
  logic up_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) up_q <= 1'b0;
    else up_q <= 1'b1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Setup phases, split into mapped accesses and unmapped reads above the status address.
  sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
  sequence s_map;
    s_setup ##0 (apb_req.paddr == sdc_pkg::CTRL_ADDR || apb_req.paddr == sdc_pkg::STAT_ADDR);
  endsequence
  sequence s_bad;
    s_setup ##0 (!apb_req.pwrite && apb_req.paddr > sdc_pkg::STAT_ADDR);
  endsequence

  property p_rst_low;
    divider_reset [*2] |=> !first_clock_out && !second_clock_out;
  endproperty
  property p_diag_low; !parallel_latch_strobe_low [*2] |=> !diag_out; endproperty
  property p_oe0; up_q |-> first_clock_out_en == $past(first_output_enable); endproperty
  property p_oe1; up_q |-> second_clock_out_en == $past(second_output_enable); endproperty
  property p_rdy; s_setup |=> apb_rsp.pready; endproperty
  property p_rdy_one; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  property p_bad; s_bad |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0; endproperty
  property p_good; s_map |=> !apb_rsp.pslverr; endproperty
  property p_q_pair; second_clock_out == first_clock_out; endproperty

  a_rst_low: assert property (p_rst_low) else $error("clock out high in reset");
  a_diag_low: assert property (p_diag_low) else $error("diag high in parallel");
  a_oe0: assert property (p_oe0) else $error("first enable wrong");
  a_oe1: assert property (p_oe1) else $error("second enable wrong");
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  a_bad: assert property (p_bad) else $error("unmapped read not refused");
  a_good: assert property (p_good) else $error("mapped access refused");
  a_q_pair: assert property (p_q_pair) else $error("clock outputs differ");
endmodule

bind sdc_config_loader sdc_chk u_chk (
  .core_clk, .rst_b, .divider_reset, .parallel_latch_strobe_low, .first_output_enable,
  .second_output_enable, .first_clock_out, .first_clock_out_en, .second_clock_out,
  .second_clock_out_en, .diag_out, .apb_req, .apb_rsp
);

// ===== testbench/sdc_ctrl_model.sv
// External controller model that drives the serial configuration pins.
`timescale 1ns/10ps
module sdc_ctrl_model (
  input wire logic core_clk,
  output logic     serial_clk,
  output logic     serial_data,
  output logic     serial_load
);
  // Pins idle low, as their pull-downs would leave them.
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    serial_load = 1'b0;
  end

  // Each level is held two core clocks so the sampled edge detector sees it.
  task automatic step();
    repeat (2) @(posedge core_clk);
  endtask

  // Mode 0 shifts only, 1 adds a transfer pulse, 2 holds the strobe high while shifting.
  task automatic send(input logic [12:0] fr, input int nb, input int md);
    if (md == 2) begin
      serial_load <= 1'b1;
      step();
    end
    for (int i = nb - 1; i >= 0; i--) begin
      serial_data <= fr[i];
      step();
      serial_clk <= 1'b1;
      step();
      serial_clk <= 1'b0;
      step();
    end
    serial_data <= 1'b0;
    if (md == 1) begin
      serial_load <= 1'b1;
      step();
    end
    serial_load <= 1'b0;
    step();
  endtask

  // Parks the data line at a chosen level.
  task automatic set_data(input logic v);
    serial_data <= v;
    step();
  endtask
endmodule

// ===== testbench/sdc_config_loader_tb.sv
// Self-checking bench for the synthesizer configuration loader.
`timescale 1ns/10ps
module sdc_config_loader_tb;
  logic                  core_clk, rst_b, divider_reset, parallel_latch_strobe_low;
  logic                  serial_clk, serial_data, serial_load, xtal_in, alt_ref_clk;
  logic                  reference_source_select, pll_bypass_select, diag_out;
  logic                  first_output_enable, second_output_enable, second_clock_out_en;
  logic                  first_clock_out, first_clock_out_en, second_clock_out;
  logic [8:0]            fb_div_pins;
  logic [1:0]            od_div_pins, ph;
  logic [32:0]           exp_q[$];
  sdc_pkg::sdc_apb_req_t apb_req;
  sdc_pkg::sdc_apb_rsp_t apb_rsp;
  sdc_pkg::sdc_cfg_t     c;
  int                    num_errors = 0, checked = 0, p, hi;
  localparam logic [11:0] CA = sdc_pkg::CTRL_ADDR, SA = sdc_pkg::STAT_ADDR;

  sdc_config_loader dut (
    .core_clk, .rst_b, .divider_reset, .parallel_latch_strobe_low, .fb_div_pins,
    .od_div_pins, .serial_clk, .serial_data, .serial_load, .reference_source_select,
    .pll_bypass_select, .first_output_enable, .second_output_enable, .xtal_in,
    .alt_ref_clk, .first_clock_out, .first_clock_out_en, .second_clock_out,
    .second_clock_out_en, .diag_out, .apb_req, .apb_rsp
  );
  sdc_ctrl_model mdl (.core_clk, .serial_clk, .serial_data, .serial_load);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, plus references: crystal period two cycles, alternate four.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // References are held low in reset so this process is their only driver.
  always @(posedge core_clk) begin
    if (rst_b !== 1'b1) begin
      ph <= 2'h0;
      xtal_in <= 1'b0;
      alt_ref_clk <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      xtal_in <= ~xtal_in;
      if (ph[0]) alt_ref_clk <= ~alt_ref_clk;
    end
  end

  task automatic bad(input string nm, input logic [32:0] e, input logic [32:0] s);
    num_errors++;
    $display("wrong value %s expected %0h seen %0h", nm, e, s);
  endtask
  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
    checked++;
    if (s !== e) bad("read", e, s);
  endtask
  task automatic cmp_n(input string nm, input int e, input int s);
    checked++;
    if (s != e) bad(nm, 33'(e), 33'(s));
  endtask

  // Takes the oldest expected answer whenever the slave completes a read.
  always @(posedge core_clk) begin
    if (apb_rsp.pready === 1'b1 && !apb_req.pwrite && exp_q.size() > 0)
      cmp_rd(exp_q.pop_front(), {apb_rsp.pslverr, apb_rsp.prdata});
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the wait is bounded so a dead slave cannot hang the run.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    apb_req <= '{1'b1, 1'b0, w, ad, d};
    if (!w) exp_q.push_back(e);
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [32:0] st(sdc_pkg::sdc_cfg_t v, logic pm, logic dr);
    return {18'h0, dr, pm, v};
  endfunction
  function automatic sdc_pkg::sdc_cfg_t rnd();
    return {2'($urandom), 2'($urandom), 9'(25 + $urandom % 7)};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Core clocks between two rising edges of the first output, zero if stopped.
  task automatic meas(output int t);
    int n, r;
    logic pv;
    n = 0;
    r = 0;
    t = 0;
    pv = 1'b1;
    while (r < 2 && n < 400) begin
      @(posedge core_clk);
      n++;
      if (r == 1) t++;
      if (first_clock_out === 1'b1 && pv === 1'b0) r++;
      pv = first_clock_out;
    end
    if (r < 2) t = 0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #1000000;
    num_errors++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, divider_reset, pll_bypass_select} = '0;
    {parallel_latch_strobe_low, reference_source_select} = 2'h3;
    {first_output_enable, second_output_enable, fb_div_pins, od_div_pins} = '1;
    apb_req = '0;
    void'($urandom(32'h7C472177));
    wt(2);
    rst_b <= 1'b1;
    wt(2);
    apb(1'b0, CA, 32'h0, 33'h0);
    apb(1'b1, SA, 32'hFFFFFFFF, 33'h0);
    // The strobe stands high as reset lifts, which reads as a rise of it.
    apb(1'b0, SA, 32'h0, 33'h0_0000_07FF);
    apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h00C, 32'h3, 33'h0);
    apb(1'b0, CA, 32'h0, 33'h0);
    $display("registers done");
    // Parallel pass-through, latch on rise, and every output divide code.
    for (int k = 0; k < 4; k++) begin
      {first_output_enable, second_output_enable} <= 2'($urandom);
      c = {2'h0, 2'(k), 9'($urandom)};
      {od_div_pins, fb_div_pins} <= {c.od, c.fb};
      parallel_latch_strobe_low <= 1'b0;
      wt(3);
      apb(1'b0, SA, 32'h0, st(c, 1'b1, 1'b0));
      parallel_latch_strobe_low <= 1'b1;
      wt(1);
      {od_div_pins, fb_div_pins} <= ~{c.od, c.fb};
      wt(3);
      apb(1'b0, SA, 32'h0, st(c, 1'b0, 1'b0));
      meas(p);
      meas(p);
      cmp_n("period", 3 + k, p);
    end
    $display("parallel done");
    c = rnd();
    mdl.send(c, 13, 1);
    apb(1'b0, SA, 32'h0, st(c, 1'b0, 1'b0));
    mdl.send(~c, 13, 0);
    apb(1'b0, SA, 32'h0, st(c, 1'b0, 1'b0));
    mdl.send(c, 0, 1);
    apb(1'b0, SA, 32'h0, st(~c, 1'b0, 1'b0));
    c = rnd();
    mdl.send(c, 13, 2);
    apb(1'b0, SA, 32'h0, st(c, 1'b0, 1'b0));
    $display("serial done");
    // Each diagnostic source, by how often the output is high: never, always, or toggling for both clock sources.
    for (int k = 0; k < 4; k++) begin
      c = rnd();
      c.diag = 2'(k);
      mdl.send(c, 13, 1);
      mdl.set_data(1'b1);
      hi = 0;
      repeat (64) begin
        @(posedge core_clk);
        hi += int'(diag_out === 1'b1);
      end
      mdl.set_data(1'b0);
      cmp_n("diag", (k == 0) ? 0 : (k == 1) ? 64 : 1, (hi % 64 == 0) ? hi : 1);
    end
    $display("diag done");
    divider_reset <= 1'b1;
    wt(3);
    apb(1'b0, SA, 32'h0, st(c, 1'b0, 1'b1));
    meas(p);
    cmp_n("period", 0, p);
    divider_reset <= 1'b0;
    apb(1'b1, CA, 32'h1, 33'h0);
    apb(1'b0, CA, 32'h0, 33'h1);
    apb(1'b0, SA, 32'h0, st(c, 1'b0, 1'b1));
    apb(1'b1, CA, 32'h0, 33'h0);
    $display("reset done");
    pll_bypass_select <= 1'b1;
    meas(p);
    meas(p);
    cmp_n("period", 2 * (3 + c.od), p);
    reference_source_select <= 1'b0;
    meas(p);
    meas(p);
    cmp_n("period", 4 * (3 + c.od), p);
    apb(1'b1, CA, 32'h2, 33'h0);
    meas(p);
    meas(p);
    cmp_n("period", 3 + c.od, p);
    $display("bypass done");
    close_out();
  end
endmodule
